// ===== design/cpu_regs_pkg.sv
// constants, types and field layout for the cpu dedicated register set.
// assumes one 40 mhz core clock and a 32-bit axi4-lite register bus.

package cpu_regs_pkg;

   // ----------------------------------------------------------------
   // bus address map (byte addresses, 12-bit window)
   // ----------------------------------------------------------------
   localparam int unsigned   AXI_ADDR_W   = 12;
   localparam logic [11:0]   OFS_IP       = 12'h000;
   localparam logic [11:0]   OFS_PRI      = 12'h004;
   localparam logic [11:0]   OFS_SEC      = 12'h008;
   localparam logic [11:0]   OFS_OFF      = 12'h00C;
   localparam logic [11:0]   OFS_AUX      = 12'h010;
   localparam logic [11:0]   OFS_STK      = 12'h014;
   localparam logic [11:0]   OFS_STAT     = 12'h018;
   localparam logic [11:0]   OFS_GP_BASE  = 12'h400;  // 256 words, 1 byte each
   localparam logic [1:0]    RESP_OKAY    = 2'b00;
   localparam logic [1:0]    RESP_DECERR  = 2'b11;

   // ----------------------------------------------------------------
   // status word layout: bank pointer high byte, condition byte low
   // ----------------------------------------------------------------
   localparam int unsigned   BANK_LSB     = 11;     // upper five bits
   localparam int unsigned   BANK_W       = 5;
   localparam int unsigned   CC_C         = 0;
   localparam int unsigned   CC_V         = 1;
   localparam int unsigned   CC_Z         = 2;
   localparam int unsigned   CC_N         = 3;
   localparam int unsigned   CC_LVL_LO    = 4;      // current_level_low
   localparam int unsigned   CC_LVL_HI    = 5;      // current_level_high
   localparam int unsigned   CC_I         = 6;
   localparam int unsigned   CC_H         = 7;

   // ----------------------------------------------------------------
   // general-purpose register area
   // ----------------------------------------------------------------
   localparam logic [15:0]   GP_PHYS_BASE = 16'h0100;
   localparam int unsigned   GP_PER_BANK  = 8;
   localparam int unsigned   GP_BANKS     = 32;
   localparam int unsigned   GP_DEPTH     = GP_PER_BANK * GP_BANKS;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0]   RST_IP       = 16'h0000;
   localparam logic [15:0]   RST_WORK     = 16'h0000;
   localparam logic [15:0]   RST_PTR      = 16'h0000;
   localparam logic [15:0]   RST_STAT     = 16'h0030;  // level 3, ie clear
   localparam logic [7:0]    RST_GP       = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_IP   = 3'h0,
      SEL_PRI  = 3'h1,
      SEL_SEC  = 3'h2,
      SEL_OFF  = 3'h3,
      SEL_AUX  = 3'h4,
      SEL_STK  = 3'h5,
      SEL_STAT = 3'h6
   } reg_sel_t;

   typedef enum logic [2:0] {
      ALU_ADD  = 3'h0,
      ALU_ADDC = 3'h1,
      ALU_SUB  = 3'h2,
      ALU_SUBC = 3'h3,
      ALU_SHL  = 3'h4,
      ALU_SHR  = 3'h5,
      ALU_ROLC = 3'h6,
      ALU_RORC = 3'h7
   } alu_op_t;

   typedef struct packed {
      logic [15:0] ip;
      logic [15:0] pri;
      logic [15:0] sec;
      logic [15:0] off;
      logic [15:0] aux;
      logic [15:0] stk;
      logic [15:0] stat;
   } cpu_regs_t;

   typedef struct packed {
      logic        en;
      reg_sel_t    sel;
      logic        byte_wide;
      logic [15:0] data;
   } core_wr_t;

   typedef struct packed {
      logic [7:0]  res;
      logic        h;
      logic        n;
      logic        z;
      logic        v;
      logic        c;
   } alu_out_t;

   typedef struct packed {
      logic        hit_reg;
      logic        hit_gp;
      reg_sel_t    sel;
      logic [7:0]  idx;
   } addr_dec_t;

endpackage

// ===== design/cpu_dedicated_register_set.sv
// dedicated register set of an 8-bit cpu core: instruction pointer,
// work registers, pointers, status word and banked general registers.
// assumes the execution logic on the same clock drives the core port
// and a host reaches every register over axi4-lite.
//
// Behaviour
// - a 16-bit instruction pointer gives the fetch position.
// - 16-bit primary work register; byte ops touch only its low byte.
// - 16-bit secondary work register is the second operand, low byte.
// - a 16-bit offset register modifies addresses for indexing.
// - a 16-bit auxiliary pointer selects a memory location.
// - a 16-bit stack pointer locates the stack area.
// - status word: high byte bank pointer, low byte condition byte.
// - the bank pointer picks the active general register bank.
// - half carry follows carry or borrow between bits 3 and 4.
// - interrupt enable flag one allows interrupts, zero blocks them.
// - reset clears the interrupt enable flag.
// - accept a request only if strictly above the current level.
// - level codes: lower code is higher priority, 11 is level 3.
// - negative flag copies the result msb.
// - zero flag set for a zero result, clear otherwise.
// - overflow flag set on two's complement overflow.
// - carry flag follows carry or borrow out of bit 7.
// - on shifts the carry flag takes the bit shifted out.
// - general registers are 8 bits, eight per bank, 32 banks.

`timescale 1ns/1ps
`default_nettype none

module cpu_dedicated_register_set (
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_i,
   // axi4-lite slave
   input  wire logic [11:0]                 s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [31:0]                 s_axi_wdata_i,
   input  wire logic [3:0]                  s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic [1:0]                       s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [11:0]                 s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic [31:0]                      s_axi_rdata_o,
   output logic [1:0]                       s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   // execution logic side
   input  wire logic                        ip_load_i,
   input  wire logic                        ip_step_i,
   input  wire logic [15:0]                 ip_value_i,
   input  wire cpu_regs_pkg::core_wr_t      core_wr_i,
   input  wire logic                        alu_go_i,
   input  wire cpu_regs_pkg::alu_op_t       alu_op_i,
   input  wire logic                        gp_wr_i,
   input  wire logic [2:0]                  gp_num_i,
   input  wire logic [7:0]                  gp_wdata_i,
   output logic [7:0]                       gp_rdata_o,
   output logic [15:0]                      gp_addr_o,
   input  wire logic                        irq_req_i,
   input  wire logic [1:0]                  irq_level_i,
   output logic                             irq_accept_o,
   output cpu_regs_pkg::cpu_regs_t          regs_o
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // pick one dedicated register by selector
   function automatic logic [15:0] get_reg(
      input cpu_regs_pkg::cpu_regs_t r,
      input cpu_regs_pkg::reg_sel_t  s
   );
      logic [15:0] v;
      v = 16'h0000;
      case (s)
         cpu_regs_pkg::SEL_IP:   v = r.ip;
         cpu_regs_pkg::SEL_PRI:  v = r.pri;
         cpu_regs_pkg::SEL_SEC:  v = r.sec;
         cpu_regs_pkg::SEL_OFF:  v = r.off;
         cpu_regs_pkg::SEL_AUX:  v = r.aux;
         cpu_regs_pkg::SEL_STK:  v = r.stk;
         cpu_regs_pkg::SEL_STAT: v = r.stat;
         default:                v = 16'h0000;
      endcase
      return v;
   endfunction

   // replace one dedicated register by selector
   function automatic cpu_regs_pkg::cpu_regs_t put_reg(
      input cpu_regs_pkg::cpu_regs_t r,
      input cpu_regs_pkg::reg_sel_t  s,
      input logic [15:0]             v
   );
      cpu_regs_pkg::cpu_regs_t o;
      o = r;
      case (s)
         cpu_regs_pkg::SEL_IP:   o.ip   = v;
         cpu_regs_pkg::SEL_PRI:  o.pri  = v;
         cpu_regs_pkg::SEL_SEC:  o.sec  = v;
         cpu_regs_pkg::SEL_OFF:  o.off  = v;
         cpu_regs_pkg::SEL_AUX:  o.aux  = v;
         cpu_regs_pkg::SEL_STK:  o.stk  = v;
         cpu_regs_pkg::SEL_STAT: o.stat = v;
         default:                o      = r;
      endcase
      return o;
   endfunction

   // bus address decode, shared by the write and read channels
   function automatic cpu_regs_pkg::addr_dec_t decode(
      input logic [11:0] a
   );
      cpu_regs_pkg::addr_dec_t d;
      d.hit_reg = (a[11:5] == 7'h00) &&
                  (a[4:2] <= cpu_regs_pkg::OFS_STAT[4:2]);
      d.hit_gp  = (a[11:10] == cpu_regs_pkg::OFS_GP_BASE[11:10]);
      d.sel     = cpu_regs_pkg::reg_sel_t'(a[4:2]);
      d.idx     = a[9:2];
      return d;
   endfunction

   // byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge_strb(
      input logic [15:0] old,
      input logic [15:0] nw,
      input logic [1:0]  strb
   );
      merge_strb = {strb[1] ? nw[15:8] : old[15:8],
                    strb[0] ? nw[7:0]  : old[7:0]};
   endfunction

   // 8-bit arithmetic and shift with condition flags
   function automatic cpu_regs_pkg::alu_out_t alu(
      input cpu_regs_pkg::alu_op_t op,
      input logic [7:0]            a,
      input logic [7:0]            b,
      input logic                  cin,
      input logic                  hold_h
   );
      cpu_regs_pkg::alu_out_t o;
      logic [8:0] wide;
      logic [4:0] nib;
      logic       ci;
      ci   = (op == cpu_regs_pkg::ALU_ADDC || op == cpu_regs_pkg::ALU_SUBC)
             ? cin : 1'b0;
      wide = 9'h000;
      nib  = 5'h00;
      o.h  = hold_h;
      o.v  = 1'b0;
      case (op)
         cpu_regs_pkg::ALU_ADD, cpu_regs_pkg::ALU_ADDC: begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            o.h  = nib[4];
            o.v  = (a[7] == b[7]) && (wide[7] != a[7]);
         end
         cpu_regs_pkg::ALU_SUB, cpu_regs_pkg::ALU_SUBC: begin
            wide = {1'b0, a} - {1'b0, b} - {8'h00, ci};
            nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
            o.h  = nib[4];
            o.v  = (a[7] != b[7]) && (wide[7] != a[7]);
         end
         // shifts put the bit shifted out into bit 8
         cpu_regs_pkg::ALU_SHL:  wide = {a, 1'b0};
         cpu_regs_pkg::ALU_SHR:  wide = {a[0], 1'b0, a[7:1]};
         cpu_regs_pkg::ALU_ROLC: wide = {a, cin};
         cpu_regs_pkg::ALU_RORC: wide = {a[0], cin, a[7:1]};
         default:                wide = 9'h000;
      endcase
      o.res = wide[7:0];
      o.c   = wide[8];
      o.n   = wide[7];
      o.z   = (wide[7:0] == 8'h00);
      return o;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cpu_regs_pkg::cpu_regs_t  regs_r;
   cpu_regs_pkg::cpu_regs_t  regs_nxt;
   logic [7:0]               gp_mem_r [cpu_regs_pkg::GP_DEPTH];
   logic [7:0]               gp_rdata_r;
   logic                     bvalid_r;
   logic [1:0]               bresp_r;
   logic                     rvalid_r;
   logic [1:0]               rresp_r;
   logic [31:0]              rdata_r;

   // ----------------------------------------------------------------
   // decode and handshakes
   // ----------------------------------------------------------------
   cpu_regs_pkg::addr_dec_t  wdec;
   cpu_regs_pkg::addr_dec_t  rdec;
   cpu_regs_pkg::alu_out_t   alu_res;
   wire logic                wr_take;
   wire logic                rd_take;
   wire logic                bus_reg_wr;
   wire logic                bus_gp_wr;
   wire logic [4:0]          bank;
   wire logic [7:0]          core_gp_idx;
   wire logic [1:0]          cur_level;

   // address and data are taken together so the response can follow
   // both; a second write waits until the response is accepted
   assign wr_take     = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r;
   assign rd_take     = s_axi_arvalid_i && !rvalid_r;
   assign wdec        = decode(s_axi_awaddr_i);
   assign rdec        = decode(s_axi_araddr_i);
   assign bus_reg_wr  = wr_take && wdec.hit_reg;
   assign bus_gp_wr   = wr_take && wdec.hit_gp && s_axi_wstrb_i[0];

   // banked register addressing from the high status byte
   assign bank        = regs_r.stat[cpu_regs_pkg::BANK_LSB +:
                                    cpu_regs_pkg::BANK_W];
   assign core_gp_idx = {bank, gp_num_i};
   assign gp_addr_o   = cpu_regs_pkg::GP_PHYS_BASE +
                        {8'h00, core_gp_idx};

   // alu works on the low bytes of the two work registers
   assign alu_res     = alu(alu_op_i, regs_r.pri[7:0], regs_r.sec[7:0],
                            regs_r.stat[cpu_regs_pkg::CC_C],
                            regs_r.stat[cpu_regs_pkg::CC_H]);

   // interrupt gate: lower code is more urgent, so strictly less wins
   assign cur_level    = {regs_r.stat[cpu_regs_pkg::CC_LVL_HI],
                          regs_r.stat[cpu_regs_pkg::CC_LVL_LO]};
   assign irq_accept_o = regs_r.stat[cpu_regs_pkg::CC_I] &&
                         irq_req_i &&
                         (irq_level_i < cur_level);

   assign s_axi_awready_o = wr_take;
   assign s_axi_wready_o  = wr_take;
   assign s_axi_arready_o = rd_take;
   assign s_axi_bvalid_o  = bvalid_r;
   assign s_axi_bresp_o   = bresp_r;
   assign s_axi_rvalid_o  = rvalid_r;
   assign s_axi_rresp_o   = rresp_r;
   assign s_axi_rdata_o   = rdata_r;
   assign gp_rdata_o      = gp_rdata_r;
   assign regs_o          = regs_r;

   // ----------------------------------------------------------------
   // next register values
   // ----------------------------------------------------------------

   // priority low to high: bus write, core write, alu, pointer step;
   // the execution logic owns the registers while it runs, so the
   // bus only wins when the core leaves a register alone
   always_comb begin
      regs_nxt = regs_r;
      if (bus_reg_wr) begin
         regs_nxt = put_reg(regs_nxt, wdec.sel,
                            merge_strb(get_reg(regs_r, wdec.sel),
                                       s_axi_wdata_i[15:0],
                                       s_axi_wstrb_i[1:0]));
      end
      if (core_wr_i.en) begin
         // byte-wide writes keep the high byte
         regs_nxt = put_reg(regs_nxt, core_wr_i.sel,
                            merge_strb(get_reg(regs_r, core_wr_i.sel),
                                       core_wr_i.data,
                                       {!core_wr_i.byte_wide, 1'b1}));
      end
      if (alu_go_i) begin
         regs_nxt.pri[7:0]                  = alu_res.res;
         regs_nxt.stat[cpu_regs_pkg::CC_H] = alu_res.h;
         regs_nxt.stat[cpu_regs_pkg::CC_N] = alu_res.n;
         regs_nxt.stat[cpu_regs_pkg::CC_Z] = alu_res.z;
         regs_nxt.stat[cpu_regs_pkg::CC_V] = alu_res.v;
         regs_nxt.stat[cpu_regs_pkg::CC_C] = alu_res.c;
      end
      if (ip_load_i) begin
         regs_nxt.ip = ip_value_i;
      end else if (ip_step_i) begin
         regs_nxt.ip = regs_r.ip + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // dedicated registers
   // ----------------------------------------------------------------

   // reset leaves interrupts blocked until software sets the flag
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         regs_r.ip   <= cpu_regs_pkg::RST_IP;
         regs_r.pri  <= cpu_regs_pkg::RST_WORK;
         regs_r.sec  <= cpu_regs_pkg::RST_WORK;
         regs_r.off  <= cpu_regs_pkg::RST_PTR;
         regs_r.aux  <= cpu_regs_pkg::RST_PTR;
         regs_r.stk  <= cpu_regs_pkg::RST_PTR;
         regs_r.stat <= cpu_regs_pkg::RST_STAT;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // ----------------------------------------------------------------
   // general register banks
   // ----------------------------------------------------------------

   // core write has priority over a bus write in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < cpu_regs_pkg::GP_DEPTH; i++) begin
            gp_mem_r[i] <= cpu_regs_pkg::RST_GP;
         end
      end else if (gp_wr_i) begin
         gp_mem_r[core_gp_idx] <= gp_wdata_i;
      end else if (bus_gp_wr) begin
         gp_mem_r[wdec.idx] <= s_axi_wdata_i[7:0];
      end
   end

   // read data lags the register number by one cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         gp_rdata_r <= cpu_regs_pkg::RST_GP;
      end else begin
         gp_rdata_r <= gp_mem_r[core_gp_idx];
      end
   end

   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------

   // write response: held until bready
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bvalid_r <= 1'b0;
         bresp_r  <= cpu_regs_pkg::RESP_OKAY;
      end else if (wr_take) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wdec.hit_reg || wdec.hit_gp) ?
                     cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_DECERR;
      end else if (s_axi_bready_i) begin
         bvalid_r <= 1'b0;
      end
   end

   // read response: sampled state of the cycle the address is taken
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rvalid_r <= 1'b0;
         rresp_r  <= cpu_regs_pkg::RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_r <= 1'b1;
         rresp_r  <= (rdec.hit_reg || rdec.hit_gp) ?
                     cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_DECERR;
         rdata_r  <= rdec.hit_reg ? {16'h0000, get_reg(regs_r, rdec.sel)} :
                     rdec.hit_gp  ? {24'h00_0000, gp_mem_r[rdec.idx]} :
                                    32'h0000_0000;
      end else if (s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== tb/regs_chk_props.sv
// checker: port relations of the cpu register set.
// assumes it is bound to the register set top module.
`timescale 1ns/1ps
`default_nettype none
module regs_chk (
   input wire logic                    core_clk_i,
   input wire logic                    rst_i,
   input wire logic                    alu_go_i,
   input wire cpu_regs_pkg::alu_op_t   alu_op_i,
   input wire logic [2:0]              gp_num_i,
   input wire logic [15:0]             gp_addr_o,
   input wire logic                    irq_req_i,
   input wire logic [1:0]              irq_level_i,
   input wire logic                    irq_accept_o,
   input wire cpu_regs_pkg::cpu_regs_t regs_o
);
   // ---------------------------------------------------------------
   // status word and flag relations
   // ---------------------------------------------------------------
   default clocking cc @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // gate and bank address follow the status word combinationally
   irq_gate_a: assert property (
      irq_accept_o == (regs_o.stat[6] && irq_req_i
      && irq_level_i < regs_o.stat[5:4])) else $error("irq accept");
   bank_addr_a: assert property (
      gp_addr_o == 16'h0100 + {8'h00, regs_o.stat[15:11], gp_num_i})
      else $error("bank address");
   // checked while reset is high, so no disable here
   reset_ie_a: assert property (
      disable iff (1'b0) rst_i |=> !regs_o.stat[6]) else $error("ie");
   // flags one cycle after a step; z and n from the result, h and c from the operands before it
   zero_flag_a: assert property (
      alu_go_i |=> regs_o.stat[2] == (regs_o.pri[7:0] == 8'h00))
      else $error("zero flag");
   neg_flag_a: assert property (
      alu_go_i |=> regs_o.stat[3] == regs_o.pri[7]) else $error("neg");
   half_carry_a: assert property (
      alu_go_i && alu_op_i == cpu_regs_pkg::ALU_ADD |=> regs_o.stat[7]
      == ($past(regs_o.pri[3:0]) + $past(regs_o.sec[3:0]) > 5'h0F))
      else $error("half carry");
   add_carry_a: assert property (
      alu_go_i && alu_op_i == cpu_regs_pkg::ALU_ADD |=> regs_o.stat[0]
      == ($past(regs_o.pri[7:0]) + $past(regs_o.sec[7:0]) > 9'h0FF))
      else $error("carry");
   shift_carry_a: assert property (
      alu_go_i && alu_op_i == cpu_regs_pkg::ALU_SHL
      |=> regs_o.stat[0] == $past(regs_o.pri[7])) else $error("shift");
endmodule
bind cpu_dedicated_register_set regs_chk i_chk (.core_clk_i, .rst_i,
   .alu_go_i, .alu_op_i, .gp_num_i, .gp_addr_o, .irq_req_i,
   .irq_level_i, .irq_accept_o, .regs_o);
`default_nettype wire

// ===== tb/exec_model.sv
// partner: execution logic on the core port of the register set.
// assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module exec_model (
   input  wire logic                   clk_i,
   output var cpu_regs_pkg::core_wr_t  core_wr_o,
   output var cpu_regs_pkg::alu_op_t   alu_op_o,
   output var logic                    alu_go_o,
   output var logic [2:0]              gp_num_o,
   output var logic                    irq_req_o,
   output var logic [1:0]              irq_level_o
);
   // ---------------------------------------------------------------
   // strobes and levels
   // ---------------------------------------------------------------
   // idle at time zero: no write, no step, no request
   initial begin
      core_wr_o = '0;
      alu_op_o = cpu_regs_pkg::ALU_ADD;
      {alu_go_o, gp_num_o, irq_req_o, irq_level_o} = 7'h00;
   end
   // one-cycle strobe; a write and a step never share a cycle here
   task automatic step(input cpu_regs_pkg::core_wr_t w, input logic g,
      input cpu_regs_pkg::alu_op_t o);
      @(posedge clk_i);
      {core_wr_o, alu_go_o, alu_op_o} <= {w, g, o};
      @(posedge clk_i);
      {core_wr_o, alu_go_o} <= '0;
   endtask
   // request and register number held as levels
   task automatic pins(input logic q, input logic [1:0] l,
      input logic [2:0] n);
      @(posedge clk_i);
      {irq_req_o, irq_level_o, gp_num_o} <= {q, l, n};
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// bench: axi4-lite traffic and execution-side stimulus.
// assumes exec_model on the core port and regs_chk bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ---------------------------------------------------------------
   // stimulus, checks and verdict
   // ---------------------------------------------------------------
   logic                    clk = 1'b0, rst = 1'b1;
   logic                    awv = 1'b0, wv = 1'b0, brd = 1'b0;
   logic                    arv = 1'b0, rrd = 1'b0, awr, arr, bv, rv;
   logic                    go, irq, acc;
   logic [1:0]              br, rr, lvl;
   logic [2:0]              num;
   logic [3:0]              ws = 4'h0;
   logic [7:0]              gr;
   logic [11:0]             awa = 12'h000, ara = 12'h000;
   logic [15:0]             gad;
   logic [31:0]             wd = 32'h0000_0000, rd;
   cpu_regs_pkg::alu_op_t   op;
   cpu_regs_pkg::core_wr_t  cw;
   cpu_regs_pkg::cpu_regs_t regs;
   int                      error_cnt = 0, samples_checked = 0;
   // 40 mhz core clock
   always #12.5 clk = ~clk;
   cpu_dedicated_register_set i_cpu_dedicated_register_set (
      .core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(),
      .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rrd), .ip_load_i(1'b0), .ip_step_i(go),
      .ip_value_i(16'h0000), .core_wr_i(cw), .alu_go_i(go),
      .alu_op_i(op), .gp_wr_i(cw.en), .gp_num_i(num),
      .gp_wdata_i(cw.data[7:0]), .gp_rdata_o(gr), .gp_addr_o(gad),
      .irq_req_i(irq), .irq_level_i(lvl), .irq_accept_o(acc), .regs_o(regs));
   exec_model exec (.clk_i(clk), .core_wr_o(cw), .alu_op_o(op),
      .alu_go_o(go), .gp_num_o(num), .irq_req_o(irq), .irq_level_o(lvl));
   // four-state compare, counted
   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one transfer; each channel held until its ready is seen high
   task automatic axi(input logic w, input logic [11:0] a,
      input logic [31:0] v, input logic [1:0] er = cpu_regs_pkg::RESP_OKAY);
      @(posedge clk);
      {awa, ara, wd, ws} <= {a, a, v, 4'hF};
      {awv, wv, brd, arv, rrd} <= {w, w, w, !w, !w};
      do @(negedge clk); while ((w ? awr : arr) !== 1'b1);
      @(posedge clk);
      {awv, wv, arv} <= 3'h0;
      do @(negedge clk); while ((w ? bv : rv) !== 1'b1);
      if (w) cmp({38'h0, br}, {38'h0, er});
      else cmp({6'h00, rr, rd}, {6'h00, er, v});
      @(posedge clk);
      {brd, rrd} <= 2'h0;
   endtask
   // reset state, then unmapped places answer with an error
   task automatic t_reset();
      axi(1'b0, cpu_regs_pkg::OFS_STAT, 32'h0000_0030);
      axi(1'b0, 12'h01C, 32'h0000_0000, cpu_regs_pkg::RESP_DECERR);
      axi(1'b1, 12'h020, 32'h0000_0001, cpu_regs_pkg::RESP_DECERR);
   endtask
   // byte steps keep the high byte; flags in h i l1 l0 n z v c order
   task automatic t_alu();
      cpu_regs_pkg::alu_op_t o [4] = '{cpu_regs_pkg::ALU_ADD,
         cpu_regs_pkg::ALU_ADD, cpu_regs_pkg::ALU_SUB, cpu_regs_pkg::ALU_SHL};
      logic [7:0]            a [4] = '{8'h0F, 8'h80, 8'h00, 8'h81};
      logic [7:0]            b [4] = '{8'h01, 8'h80, 8'h01, 8'h00};
      logic [7:0]            s [4] = '{8'h10, 8'h00, 8'hFF, 8'h02};
      logic [7:0]            f [4] = '{8'hB0, 8'h37, 8'hB9, 8'hB1};
      for (int i = 0; i < 4; i++) begin
         exec.step({1'b1, cpu_regs_pkg::SEL_SEC, 1'b0, 8'hCD, b[i]},1'b0,o[i]);
         exec.step({1'b1, cpu_regs_pkg::SEL_PRI, 1'b1, 8'hAB, a[i]},1'b0,o[i]);
         exec.step('0, 1'b1, o[i]);
         @(negedge clk);
         cmp({24'h0, regs.pri}, {24'h0, 8'h00, s[i]});
         cmp({24'h0, regs.stat}, {32'h0, f[i]});
         cmp({24'h0, regs.ip}, 40'(i + 1));
      end
      // the core also copied each operand into bank 0, register 0
      axi(1'b0, 12'h400, 32'h0000_0081);
      cmp({32'h0, gr}, 40'h81);
   endtask
   // bank pointer picks the register area, bank 5 and highest bank
   task automatic t_bank();
      axi(1'b1, cpu_regs_pkg::OFS_STAT, 32'h0000_2830);
      axi(1'b0, cpu_regs_pkg::OFS_STAT, 32'h0000_2830);
      exec.pins(1'b0, 2'h0, 3'h3);
      @(negedge clk);
      cmp({24'h0, gad}, 40'h00_0000_012B);
      axi(1'b1, cpu_regs_pkg::OFS_STAT, 32'h0000_F830);
      exec.pins(1'b0, 2'h0, 3'h7);
      @(negedge clk);
      cmp({24'h0, gad}, 40'h00_0000_01FF);
   endtask
   // level 2 enabled: only a strictly higher request passes; with the enable flag clear, none passes
   task automatic t_irq();
      axi(1'b1, cpu_regs_pkg::OFS_STAT, 32'h0000_0060);
      exec.pins(1'b1, 2'h1, 3'h0);
      @(negedge clk);
      cmp({39'h0, acc}, 40'h1);
      exec.pins(1'b1, 2'h2, 3'h0);
      @(negedge clk);
      cmp({39'h0, acc}, 40'h0);
      axi(1'b1, cpu_regs_pkg::OFS_STAT, 32'h0000_0020);
      exec.pins(1'b1, 2'h0, 3'h0);
      @(negedge clk);
      cmp({39'h0, acc}, 40'h0);
   endtask
   // reset for four cycles, then the scenarios in turn
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_alu();
      t_bank();
      t_irq();
      complete_run();
   end
   // watchdog: the run needs a few hundred cycles at most
   initial begin
      #50000;
      error_cnt++;
      complete_run();
   end
endmodule
`default_nettype wire
